// >>> hw/wdcr_pkg.sv
// constants shared by the watchdog counter block
package wdcr_pkg;
    localparam int unsigned CLK_FREQ_HZ       = 200_000_000;
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    // standby interval after deep supply collapse, in microseconds
    localparam int unsigned STANDBY_US        = 20;
    localparam int unsigned STANDBY_CYCLES    = (STANDBY_US * 1_000_000) / CLK_PERIOD_PS;
    // default capacitor period in clock cycles, per charge-discharge cycle
    localparam int unsigned TICK_DIV_DEFAULT  = 64;
    // default discharge time in clock cycles
    localparam int unsigned DISCH_DEFAULT     = 8;
    localparam int unsigned WDT_CYCLES        = 32;
    localparam int unsigned POR_CYCLES        = 4;
    localparam int unsigned INIT_CYCLES_DEF   = 16;

    typedef enum logic [2:0] {
        WDCR_POR_INIT  = 3'b000,
        WDCR_POR_CYCLE = 3'b001,
        WDCR_RUN       = 3'b011,
        WDCR_POR_DISCH = 3'b010,
        WDCR_STANDBY   = 3'b110
    } wdcr_por_t;

    typedef enum logic [1:0] {
        WDCR_WD_IDLE  = 2'b00,
        WDCR_WD_CYCLE = 2'b01,
        WDCR_WD_DISCH = 2'b11,
        WDCR_WD_TOUT  = 2'b10
    } wdcr_wd_t;
endpackage

// >>> hw/wdcr_tick.sv
// capacitor period divider giving one tick per charge-discharge cycle
`timescale 1ns/1ps
module wdcr_tick #(
    parameter int unsigned DIV = 64
) (
    input  wire logic mclk_i,    // system clock
    input  wire logic reset_i,   // async reset, high
    input  wire logic run_i,     // capacitor cycling
    output logic      tick_o     // one-cycle tick
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

    initial
    begin
        if (DIV < 2)
            $error("wdcr_tick: DIV must be at least 2");
    end

    logic [W-1:0] cnt_r;

    // counter restarts from zero whenever cycling stops
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            cnt_r <= '0;
        else if (!run_i)
            cnt_r <= '0;
        else if (cnt_r == W'(DIV - 1))
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + W'(1);
    end

    assign tick_o = run_i && (cnt_r == W'(DIV - 1)); // see R13
endmodule

// >>> hw/wdcr_top.sv
// watchdog counter with kick, enable and supply restart sequencing
`timescale 1ns/1ps
// Notes on behaviour
// R01: enable falling during cycling discharges the watchdog capacitor and stops cycling.
// R02: enable falling clears the watchdog cycle counter to zero.
// R03: enable returning high restarts cycling from a cleared count.
// R04: rising-edge variant: only kick rising edge clears the counter.
// R05: falling-edge variant: only kick falling edge clears the counter.
// R06: low supply during reset cycling finishes discharge before new reset cycles.
// R07: after collapse to 0.9 V hold 20 us standby before initialization.
// R08: short dip still reruns the full power-on reset cycling before watchdog.
// R09: 32 watchdog cycles without clear drive the timeout output low.
// R10: kick edge discharges, clears the counter, resumes after discharge.
// R11: reset and timeout outputs rise after 4 reset-delay cycles.
// R12: enable low at reset release: no watchdog cycling until enable high.
// R13: each capacitor cycle is one tick from a configurable divider.
// R14: host kicks within 32 cycles and keeps enable at a valid level.
module wdcr_top #(
    parameter bit          RISE_EDGE   = 1'b1,                       // kick edge variant
    parameter int unsigned WDT_DIV     = wdcr_pkg::TICK_DIV_DEFAULT, // watchdog cycle clocks
    parameter int unsigned POR_DIV     = wdcr_pkg::TICK_DIV_DEFAULT, // reset cycle clocks
    parameter int unsigned DISCH_CLKS  = wdcr_pkg::DISCH_DEFAULT,    // discharge clocks
    parameter int unsigned INIT_CLKS   = wdcr_pkg::INIT_CYCLES_DEF,  // initialization clocks
    parameter int unsigned STBY_CLKS   = wdcr_pkg::STANDBY_CYCLES    // standby clocks
) (
    input  wire logic mclk_i,            // 200 MHz clock
    input  wire logic reset_i,           // async reset, high
    input  wire logic supply_low_i,      // supply below detection voltage
    input  wire logic supply_dead_i,     // supply at or below 0.9 V
    input  wire logic watchdog_en_i,     // watchdog enable, high
    input  wire logic kick_input_i,      // service kick
    output logic      reset_n_o,         // reset output, low active
    output logic      timeout_output_n_o,// timeout output, low active
    output logic      wd_cap_charge_o,   // watchdog capacitor cycling
    output logic      wd_cap_disch_o,    // watchdog capacitor discharging
    output logic      por_cap_disch_o,   // reset-delay capacitor discharging
    output logic [5:0] wd_count_o        // watchdog cycle tally
);
    localparam int unsigned DW = $clog2(DISCH_CLKS + 1);
    localparam int unsigned SW = $clog2(STBY_CLKS + INIT_CLKS + 1);

    initial
    begin
        if (DISCH_CLKS < 1 || INIT_CLKS < 1 || STBY_CLKS < 1)
            $error("wdcr_top: discharge, init and standby counts must be at least 1");
    end

    // ----------------------------------------------------------------
    // input edge detection
    // ----------------------------------------------------------------
    logic kick_d_r;
    logic en_d_r;
    logic kick_edge;
    logic en_fall;

    // inputs are already synchronous, one stage suffices for edges
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            kick_d_r <= 1'b0;
            en_d_r   <= 1'b0;
        end
        else
        begin
            kick_d_r <= kick_input_i;
            en_d_r   <= watchdog_en_i;
        end
    end

    assign kick_edge = RISE_EDGE ? (kick_input_i && !kick_d_r)   // see R04
                                 : (!kick_input_i && kick_d_r);  // see R05
    assign en_fall   = en_d_r && !watchdog_en_i;

    // ----------------------------------------------------------------
    // supply and reset-timeout sequencing
    // ----------------------------------------------------------------
    wdcr_pkg::wdcr_por_t por_st_r;
    logic [SW-1:0]       por_tmr_r;
    logic [DW-1:0]       pdis_r;
    logic [2:0]          por_cnt_r;
    logic                por_tick;
    logic                dead_seen_r;

    wdcr_tick #(.DIV(POR_DIV)) u_por_tick (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .run_i   (por_st_r == wdcr_pkg::WDCR_POR_CYCLE),
        .tick_o  (por_tick)
    );

    // a collapse to 0.9 V is remembered so the next rise waits for standby
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            dead_seen_r <= 1'b1;
        else if (supply_dead_i)
            dead_seen_r <= 1'b1;
        else if (por_st_r == wdcr_pkg::WDCR_STANDBY && por_tmr_r == '0)
            dead_seen_r <= 1'b0;
    end

    // power-on sequence; any dip after standby restarts it from the discharge step, without standby
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            por_st_r  <= wdcr_pkg::WDCR_STANDBY;
            por_tmr_r <= SW'(STBY_CLKS);
            pdis_r    <= '0;
            por_cnt_r <= '0;
        end
        else if (supply_dead_i)
        begin
            por_st_r  <= wdcr_pkg::WDCR_STANDBY;           // see R07
            por_cnt_r <= '0;
            if (!dead_seen_r)
                por_tmr_r <= SW'(STBY_CLKS);               // standby timed from the collapse
            else if (por_tmr_r != '0)
                por_tmr_r <= por_tmr_r - SW'(1);           // a long collapse adds no delay
            if (pdis_r != '0)
                pdis_r <= pdis_r - DW'(1);
        end
        else if (supply_low_i)
        begin
            // a dip, however short, reruns initialization and all reset cycles; discharge only when it hits reset cycling
            por_cnt_r <= '0;                                // see R08
            if (por_st_r == wdcr_pkg::WDCR_POR_CYCLE)
                pdis_r <= DW'(DISCH_CLKS);                  // see R06
            else if (pdis_r != '0)
                pdis_r <= pdis_r - DW'(1);
            if (por_st_r != wdcr_pkg::WDCR_STANDBY)
                por_st_r <= wdcr_pkg::WDCR_POR_DISCH;
        end
        else
        begin
            unique case (por_st_r)
                wdcr_pkg::WDCR_STANDBY:
                begin
                    if (pdis_r != '0)
                        pdis_r <= pdis_r - DW'(1);
                    if (por_tmr_r != '0)
                        por_tmr_r <= por_tmr_r - SW'(1);   // see R07
                    else
                    begin
                        por_st_r  <= wdcr_pkg::WDCR_POR_DISCH;
                        por_tmr_r <= SW'(INIT_CLKS);
                    end
                end
                // new reset cycles wait for the old discharge to end
                wdcr_pkg::WDCR_POR_DISCH:
                    if (pdis_r != '0)
                        pdis_r <= pdis_r - DW'(1);          // see R06
                    else
                    begin
                        por_st_r  <= wdcr_pkg::WDCR_POR_INIT;
                        por_tmr_r <= SW'(INIT_CLKS);
                    end
                wdcr_pkg::WDCR_POR_INIT:
                    if (por_tmr_r > SW'(1))
                        por_tmr_r <= por_tmr_r - SW'(1);
                    else
                        por_st_r <= wdcr_pkg::WDCR_POR_CYCLE;
                wdcr_pkg::WDCR_POR_CYCLE:
                    if (por_tick)
                    begin
                        if (por_cnt_r == 3'(wdcr_pkg::POR_CYCLES - 1))
                            por_st_r <= wdcr_pkg::WDCR_RUN; // see R11
                        por_cnt_r <= por_cnt_r + 3'(1);
                    end
                wdcr_pkg::WDCR_RUN:
                    por_cnt_r <= por_cnt_r;
                default:
                    por_st_r <= wdcr_pkg::WDCR_STANDBY;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // watchdog cycling and tally
    // ----------------------------------------------------------------
    wdcr_pkg::wdcr_wd_t wd_st_r;
    logic [5:0]         wd_cnt_r;
    logic [DW-1:0]      wdis_r;
    logic               wd_tick;
    logic               released;

    assign released = (por_st_r == wdcr_pkg::WDCR_RUN);

    wdcr_tick #(.DIV(WDT_DIV)) u_wd_tick ( // see R13
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .run_i   (wd_st_r == wdcr_pkg::WDCR_WD_CYCLE),
        .tick_o  (wd_tick)
    );

    // watchdog only runs after release and while enabled
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wd_st_r  <= wdcr_pkg::WDCR_WD_IDLE;
            wd_cnt_r <= '0;
            wdis_r   <= '0;
        end
        else if (!released)
        begin
            // supply events hold counting off until reset cycling ends
            wd_st_r  <= wdcr_pkg::WDCR_WD_IDLE;             // see R08
            wd_cnt_r <= '0;
            wdis_r   <= '0;
        end
        else
        begin
            unique case (wd_st_r)
                wdcr_pkg::WDCR_WD_IDLE:
                    if (wdis_r != '0)
                        wdis_r <= wdis_r - DW'(1);
                    else if (watchdog_en_i)
                        wd_st_r <= wdcr_pkg::WDCR_WD_CYCLE; // see R03 R12
                wdcr_pkg::WDCR_WD_CYCLE:
                    if (en_fall || !watchdog_en_i)
                    begin
                        wd_st_r  <= wdcr_pkg::WDCR_WD_IDLE; // see R01
                        wdis_r   <= DW'(DISCH_CLKS);
                        wd_cnt_r <= '0;                      // see R02
                    end
                    else if (kick_edge)
                    begin
                        wd_st_r  <= wdcr_pkg::WDCR_WD_DISCH; // see R10
                        wdis_r   <= DW'(DISCH_CLKS);
                        wd_cnt_r <= '0;
                    end
                    else if (wd_tick)
                    begin
                        wd_cnt_r <= wd_cnt_r + 6'(1);
                        if (wd_cnt_r == 6'(wdcr_pkg::WDT_CYCLES - 1))
                            wd_st_r <= wdcr_pkg::WDCR_WD_TOUT; // see R09
                    end
                wdcr_pkg::WDCR_WD_DISCH:
                    if (!watchdog_en_i)
                    begin
                        wd_st_r  <= wdcr_pkg::WDCR_WD_IDLE; // see R01
                        wd_cnt_r <= '0;
                    end
                    else if (wdis_r > DW'(1))
                        wdis_r <= wdis_r - DW'(1);
                    else
                    begin
                        wdis_r  <= '0;
                        wd_st_r <= wdcr_pkg::WDCR_WD_CYCLE; // see R10
                    end
                // timeout holds until a clear; a kick restarts cycling
                wdcr_pkg::WDCR_WD_TOUT:
                    if (!watchdog_en_i)
                    begin
                        wd_st_r  <= wdcr_pkg::WDCR_WD_IDLE;
                        wd_cnt_r <= '0;
                    end
                    else if (kick_edge)
                    begin
                        wd_st_r  <= wdcr_pkg::WDCR_WD_DISCH;
                        wdis_r   <= DW'(DISCH_CLKS);
                        wd_cnt_r <= '0;
                    end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic rst_n_r;
    logic tout_n_r;

    // registered outputs; both held low until release
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rst_n_r  <= 1'b0;
            tout_n_r <= 1'b0;
        end
        else
        begin
            rst_n_r  <= released && !supply_low_i && !supply_dead_i;               // see R11
            tout_n_r <= released && !supply_low_i && !supply_dead_i
                        && (wd_st_r != wdcr_pkg::WDCR_WD_TOUT);                     // see R09
        end
    end

    assign reset_n_o          = rst_n_r;
    assign timeout_output_n_o = tout_n_r;
    assign wd_cap_charge_o    = (wd_st_r == wdcr_pkg::WDCR_WD_CYCLE);
    assign wd_cap_disch_o     = (wd_st_r == wdcr_pkg::WDCR_WD_DISCH) || (wdis_r != '0);
    assign por_cap_disch_o    = (pdis_r != '0);
    assign wd_count_o         = wd_cnt_r;
endmodule

// >>> bench/wdcr_host.sv
// host processor model driving the enable and kick pins
`timescale 1ns/1ps
module wdcr_host (
    input  wire logic mclk_i,        // system clock
    input  wire logic reset_i,       // async reset, high
    input  wire logic en_cmd_i,      // requested enable level
    input  wire logic kick_cmd_i,    // request one kick toggle
    output logic      watchdog_en_o, // enable to the block
    output logic      kick_o         // kick level to the block
);
    // enable always at a valid level, low after reset
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            watchdog_en_o <= 1'b0;
        else
            watchdog_en_o <= en_cmd_i;
    end

    // each request flips the kick level, so the bench picks the edge
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            kick_o <= 1'b1;
        else if (kick_cmd_i)
            kick_o <= ~kick_o;
    end
endmodule

// >>> bench/wdcr_top_sva.sv
// port checker for the watchdog counter block
`timescale 1ns/1ps
module wdcr_top_sva #(
    parameter bit          RISE_EDGE = 1'b1,                      // kick edge variant
    parameter int unsigned POR_DIV   = wdcr_pkg::TICK_DIV_DEFAULT // reset cycle clocks
) (
    input  wire logic       mclk_i,             // system clock
    input  wire logic       reset_i,            // async reset, high
    input  wire logic       supply_low_i,       // supply below detection voltage
    input  wire logic       supply_dead_i,      // supply collapsed
    input  wire logic       watchdog_en_i,      // watchdog enable
    input  wire logic       kick_input_i,       // service kick
    input  wire logic       reset_n_o,          // reset output, low active
    input  wire logic       timeout_output_n_o, // timeout output, low active
    input  wire logic       wd_cap_charge_o,    // watchdog cycling
    input  wire logic       wd_cap_disch_o,     // watchdog discharging
    input  wire logic       por_cap_disch_o,    // reset-delay discharging
    input  wire logic [5:0] wd_count_o          // watchdog cycle tally
);
    logic [15:0] low_cnt_r;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // ----
    // helper: length of the current reset-low spell, saturating
    // ----
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            low_cnt_r <= 16'h0000;
        else if (reset_n_o)
            low_cnt_r <= 16'h0000;
        else if (low_cnt_r != 16'hffff)
            low_cnt_r <= low_cnt_r + 16'h0001;
    end

    // ----
    // assertions
    // ----
    AST_EN_LOW_STOP: assert property (!watchdog_en_i && wd_cap_charge_o |=> wd_count_o == 6'h00 && !wd_cap_charge_o)
        else $error("enable low did not stop and clear");
    AST_KICK_CLEAR: assert property ((RISE_EDGE ? $rose(kick_input_i) : $fell(kick_input_i))
        && wd_cap_charge_o && watchdog_en_i && !supply_low_i |=> wd_count_o == 6'h00 && wd_cap_disch_o)
        else $error("selected kick edge did not clear");
    AST_FALL_IGNORED: assert property ((RISE_EDGE ? $fell(kick_input_i) : $rose(kick_input_i))
        && wd_cap_charge_o && watchdog_en_i && !supply_low_i
        && wd_count_o inside {[6'h01:6'h1e]} |=> wd_count_o != 6'h00)
        else $error("opposite kick edge cleared the count");
    AST_IDLE_HOLD: assert property (!watchdog_en_i && !wd_cap_charge_o |=> !wd_cap_charge_o)
        else $error("cycling started while disabled");
    AST_TIMEOUT_LATE: assert property ($fell(timeout_output_n_o) && reset_n_o |-> $past(wd_count_o) >= 6'h1f)
        else $error("timeout before 32 cycles");
    AST_COUNT_STEP: assert property (wd_count_o != $past(wd_count_o)
        |-> wd_count_o == $past(wd_count_o) + 6'h01 || wd_count_o == 6'h00)
        else $error("count moved by more than one");
    AST_DISCH_END: assert property ($rose(wd_cap_disch_o) |-> ##[1:12] !wd_cap_disch_o)
        else $error("discharge never completed");
    AST_SUPPLY_LOW: assert property (supply_low_i |=> !reset_n_o && !timeout_output_n_o)
        else $error("low supply not flagged");
    AST_POR_LEN: assert property ($rose(reset_n_o) |-> timeout_output_n_o && low_cnt_r >= 16'(4 * POR_DIV))
        else $error("reset released too early");
endmodule

bind wdcr_top wdcr_top_sva #(.RISE_EDGE(RISE_EDGE), .POR_DIV(POR_DIV)) wdcr_top_sva_inst (.mclk_i(mclk_i),
    .reset_i(reset_i),
    .supply_low_i(supply_low_i), .supply_dead_i(supply_dead_i), .watchdog_en_i(watchdog_en_i),
    .kick_input_i(kick_input_i), .reset_n_o(reset_n_o), .timeout_output_n_o(timeout_output_n_o),
    .wd_cap_charge_o(wd_cap_charge_o), .wd_cap_disch_o(wd_cap_disch_o),
    .por_cap_disch_o(por_cap_disch_o), .wd_count_o(wd_count_o));

// >>> bench/tb.sv
// self-checking bench for the watchdog counter block
`timescale 1ns/1ps
module tb;
    localparam int WDIV = 4;
    localparam int PDIV = 4;
    localparam int DCLK = 8;
    localparam int ICLK = 16;
    localparam int SCLK = 10;
    logic       mclk_i, reset_i, supply_low_i, supply_dead_i, en_cmd, kick_cmd;
    logic       watchdog_en_i, kick_input_i, reset_n_o, timeout_output_n_o;
    logic       wd_cap_charge_o, wd_cap_disch_o, por_cap_disch_o;
    logic [5:0] wd_count_o;
    logic       fall_tout_n, fall_disch;
    logic [5:0] fall_count;
    int         miscompares, total_checks, n;

    wdcr_top #(.RISE_EDGE(1'b1), .WDT_DIV(WDIV), .POR_DIV(PDIV), .DISCH_CLKS(DCLK), .INIT_CLKS(ICLK),
        .STBY_CLKS(SCLK)) wdcr_top_inst (.mclk_i(mclk_i), .reset_i(reset_i), .supply_low_i(supply_low_i),
        .supply_dead_i(supply_dead_i), .watchdog_en_i(watchdog_en_i), .kick_input_i(kick_input_i),
        .reset_n_o(reset_n_o), .timeout_output_n_o(timeout_output_n_o), .wd_cap_charge_o(wd_cap_charge_o),
        .wd_cap_disch_o(wd_cap_disch_o), .por_cap_disch_o(por_cap_disch_o), .wd_count_o(wd_count_o));
    wdcr_host wdcr_host_inst (.mclk_i(mclk_i), .reset_i(reset_i), .en_cmd_i(en_cmd), .kick_cmd_i(kick_cmd),
        .watchdog_en_o(watchdog_en_i), .kick_o(kick_input_i));
    // falling-edge variant on the same stimulus, so one kick sequence covers both
    wdcr_top #(.RISE_EDGE(1'b0), .WDT_DIV(WDIV), .POR_DIV(PDIV), .DISCH_CLKS(DCLK), .INIT_CLKS(ICLK),
        .STBY_CLKS(SCLK)) wdcr_top_fall_inst (.mclk_i(mclk_i), .reset_i(reset_i), .supply_low_i(supply_low_i),
        .supply_dead_i(supply_dead_i), .watchdog_en_i(watchdog_en_i), .kick_input_i(kick_input_i),
        .reset_n_o(), .timeout_output_n_o(fall_tout_n), .wd_cap_charge_o(),
        .wd_cap_disch_o(fall_disch), .por_cap_disch_o(), .wd_count_o(fall_count));

    // clock at 200 MHz
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // ----
    // shared tasks
    // ----
    task automatic summarize();
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tk(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    // selectable condition to wait on
    function automatic logic sel(input int w);
        case (w)
            0: sel = reset_n_o;
            1: sel = !timeout_output_n_o;
            2: sel = wd_cap_charge_o;
            default: sel = wd_count_o >= 6'h03;
        endcase
    endfunction

    // bounded wait; running out ends the run as a failure
    task automatic waitfor(input int w, input int lim, output int cnt);
        cnt = 0;
        while (sel(w) !== 1'b1)
        begin
            tk(1);
            cnt++;
            if (cnt > lim)
            begin
                miscompares++;
                summarize();
            end
        end
    endtask

    task automatic en(input logic v);
        @(posedge mclk_i);
        en_cmd <= v;
    endtask

    task automatic kick();
        @(posedge mclk_i);
        kick_cmd <= 1'b1;
        @(posedge mclk_i);
        kick_cmd <= 1'b0;
    endtask

    task automatic sup(input logic l, input logic d);
        @(posedge mclk_i);
        supply_low_i <= l;
        supply_dead_i <= d;
    endtask

    // ----
    // scenarios
    // ----
    task automatic s_release();
        waitfor(0, 300, n);
        chk({5'h0, n >= SCLK + ICLK + 4 * PDIV}, 6'h01);
        chk({5'h0, timeout_output_n_o}, 6'h01);
        tk(20);
        chk({5'h0, wd_cap_charge_o}, 6'h00);
    endtask

    task automatic s_timeout();
        en(1'b1);
        waitfor(2, 10, n);
        waitfor(1, 32 * WDIV + 20, n);
        chk({5'h0, n >= 32 * WDIV - 2 && n <= 32 * WDIV + 4}, 6'h01);
    endtask

    // falling kick ignored, rising kick clears, in timeout and in cycling
    task automatic s_kick();
        kick();
        tk(4);
        chk({5'h0, timeout_output_n_o}, 6'h00);
        chk({5'h0, fall_tout_n}, 6'h01);
        kick();
        tk(3);
        chk({5'h0, timeout_output_n_o}, 6'h01);
        waitfor(3, 40, n);
        kick();
        tk(3);
        chk({5'h0, wd_count_o != 6'h00}, 6'h01);
        chk(fall_count, 6'h00);
        chk({5'h0, fall_disch}, 6'h01);
        kick();
        tk(3);
        chk(wd_count_o, 6'h00);
        chk({5'h0, wd_cap_disch_o}, 6'h01);
    endtask

    task automatic s_enable();
        waitfor(3, 60, n);
        en(1'b0);
        tk(3);
        chk(wd_count_o, 6'h00);
        tk(30);
        chk({5'h0, wd_cap_charge_o}, 6'h00);
        en(1'b1);
        waitfor(2, DCLK + 10, n);
        chk(wd_count_o, 6'h00);
    endtask

    // two dips while running, then a third dip during reset cycling, then a collapse
    task automatic s_supply();
        sup(1'b1, 1'b0);
        sup(1'b0, 1'b0);
        tk(1);
        chk({4'h0, reset_n_o, timeout_output_n_o}, 6'h00);
        waitfor(0, 200, n);
        chk({5'h0, n >= ICLK + 4 * PDIV}, 6'h01);
        sup(1'b1, 1'b0);
        sup(1'b0, 1'b0);
        tk(ICLK + PDIV);
        sup(1'b1, 1'b0);
        sup(1'b0, 1'b0);
        tk(1);
        chk({5'h0, por_cap_disch_o}, 6'h01);
        waitfor(0, 200, n);
        chk({5'h0, n >= DCLK + ICLK + 4 * PDIV - 4}, 6'h01);
        sup(1'b1, 1'b1);
        sup(1'b0, 1'b0);
        tk(1);
        waitfor(0, 200, n);
        chk({5'h0, n >= SCLK + ICLK + 4 * PDIV}, 6'h01);
    endtask

    // main sequence
    initial
    begin
        miscompares = 0;
        total_checks = 0;
        reset_i = 1'b1;
        supply_low_i = 1'b0;
        supply_dead_i = 1'b0;
        en_cmd = 1'b0;
        kick_cmd = 1'b0;
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        s_release();
        s_timeout();
        s_kick();
        s_enable();
        s_supply();
        summarize();
    end
endmodule
